// ===== hw/canrw_regs.svh
// Register offsets, field positions, reset values of the CAN RAM watchdog,
// timestamp and mask block. Assumes byte addresses decoded from haddr[7:0].
`ifndef CANRW_REGS_SVH
`define CANRW_REGS_SVH

// Register byte offsets.
`define CANRW_OFS_TEST 8'h10
`define CANRW_OFS_RWD 8'h14
`define CANRW_OFS_CCCTL 8'h18
`define CANRW_OFS_TSCC 8'h20
`define CANRW_OFS_TSCV 8'h24
`define CANRW_OFS_IRQ_STAT 8'h50
`define CANRW_OFS_IRQ_CLR 8'h54
`define CANRW_OFS_IRQ_EN 8'h58
`define CANRW_OFS_XIDAM 8'h90

// Field positions.
`define CANRW_LOOP_BIT 4
`define CANRW_TXCTL_LSB 5
`define CANRW_WD_START_LSB 0
`define CANRW_WD_COUNT_LSB 8
`define CANRW_INIT_BIT 0
`define CANRW_CFG_CHG_BIT 1
`define CANRW_TEST_BIT 7
`define CANRW_TS_SRC_LSB 0
`define CANRW_TS_PSC_LSB 16
`define CANRW_IRQ_WRAP_BIT 0
`define CANRW_IRQ_WDTO_BIT 1

// Reset values.
`define CANRW_XIDAM_RST 29'h1FFFFFFF
`define CANRW_INIT_RST 1'b1
`define CANRW_PIN_RST 1'b1

`endif

// ===== hw/canrw_pkg.sv
// Types shared by the CAN RAM watchdog, timestamp and mask block.
// Assumes nothing of its surroundings.
`default_nettype none

package canrw_pkg;
  // Transmit pin control in test operation; codes follow declaration order.
  typedef enum logic [1:0] {
    canrw_tx_core,
    canrw_tx_sample,
    canrw_tx_dominant,
    canrw_tx_recessive
  } canrw_txctl_e;

  // Timestamp source: held at zero, internal counter, external counter.
  typedef enum logic [1:0] {
    canrw_ts_zero,
    canrw_ts_int,
    canrw_ts_ext,
    canrw_ts_zero_alt
  } canrw_ts_src_e;

  // A 29-bit extended identifier.
  typedef logic [28:0] canrw_id_t;
endpackage : canrw_pkg

`default_nettype wire

// ===== hw/canrw_watchdog.sv
// Message RAM access watchdog down-counter.
// Assumes access_start and ram_ready are one-cycle pulses on clk.
`default_nettype none

module canrw_watchdog (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] start_value,
  input wire logic access_start,
  input wire logic ram_ready,
  output logic [7:0] count_now,
  output logic timeout
);

  // High while a RAM access waits for its ready.
  logic pending_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Counter. It runs on the peripheral clock, never on a bit-time tick.
  // peripheral clock only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_now <= 8'h00;
    end else if (start_value == 8'h00) begin
      count_now <= 8'h00;
    end else if (access_start || ram_ready) begin
      count_now <= start_value;
    end else if (pending_reg && count_now != 8'h00) begin
      count_now <= count_now - 8'h01;
    end
  end

  // Pending flag. A new access wins over a ready in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_reg <= 1'b0;
    end else if (start_value == 8'h00) begin
      pending_reg <= 1'b0;
    end else if (access_start) begin
      pending_reg <= 1'b1;
    end else if (ram_ready || count_now == 8'h00) begin
      pending_reg <= 1'b0;
    end
  end

  // Timeout pulse, one cycle, when the count runs out unanswered.
  // flag on expiry
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout <= 1'b0;
    end else begin
      timeout <= (start_value != 8'h00) && pending_reg && (count_now == 8'h00) &&
        !ram_ready && !access_start;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_expire;
    (start_value != 8'h00) && pending_reg && count_now == 8'h00 && !ram_ready &&
      !access_start;
  endsequence

  a_wd_load: assert property (@(posedge clk) disable iff (!rst_b)
    access_start && start_value != 8'h00 |=> count_now == $past(start_value))
    else $error("watchdog not loaded on access");
  a_wd_count_down: assert property (@(posedge clk) disable iff (!rst_b)
    pending_reg && count_now != 8'h00 && !access_start && !ram_ready &&
      start_value != 8'h00 && $stable(start_value)
      |=> count_now == $past(count_now) - 8'h01)
    else $error("watchdog did not decrement");
  a_wd_expire: assert property (@(posedge clk) disable iff (!rst_b)
    s_expire |=> timeout ##1 (!timeout && count_now == 8'h00))
    else $error("watchdog expiry not flagged");
  a_wd_disabled: assert property (@(posedge clk) disable iff (!rst_b)
    timeout |-> $past(start_value) != 8'h00)
    else $error("disabled watchdog timed out");

endmodule : canrw_watchdog

`default_nettype wire

// ===== hw/canrw_top.sv
// CAN controller support logic: RAM watchdog, timestamp, extended mask,
// transmit pin test control, interrupt status, AHB-Lite register slave.
// Assumes the CAN core, message RAM and timestamp source share clk.
`include "canrw_regs.svh"
`default_nettype none

module canrw_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  input wire logic ram_access_start,
  input wire logic ram_ready,
  input wire logic bit_time_tick,
  input wire logic frame_start,
  input wire logic [15:0] ext_timestamp,
  output logic [15:0] captured_timestamp,
  input wire logic rx_id_valid,
  input wire logic [28:0] rx_ext_id,
  output logic masked_id_valid,
  output logic [28:0] masked_ext_id,
  input wire logic core_tx,
  output logic core_rx,
  output logic can_transmit_pin,
  input wire logic can_receive_pin,
  output logic loopback_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic wr_pend_reg; // Write data phase follows.
  logic [7:0] wr_addr_reg; // Offset of the pending write.
  canrw_pkg::canrw_txctl_e txctl_reg; // Transmit pin control.
  logic [7:0] wd_start_reg; // Watchdog start value.
  logic init_reg; // Initialisation bit.
  logic cfg_chg_reg; // Configuration change enable.
  logic test_reg; // Test operation enable.
  canrw_pkg::canrw_ts_src_e ts_src_reg; // Timestamp source.
  logic [3:0] ts_psc_reg; // Timestamp prescale, N minus one.
  canrw_pkg::canrw_id_t mask_reg; // Extended identifier mask.
  logic [1:0] irq_en_reg; // Interrupt enables.
  logic [1:0] irq_stat_reg; // Sticky interrupt status.
  logic [31:0] rdata_next; // Read data for the address phase.
  logic rd_take; // Read taken this cycle.
  logic wr_take; // Write taken this cycle.

  // Timestamp and watchdog state.
  logic [15:0] ts_int_reg; // Internal timestamp counter.
  logic [3:0] psc_reg; // Bit-time prescaler.
  logic [15:0] ext_prev_reg; // External value one cycle back.
  logic [15:0] ts_now; // Timestamp as software sees it.
  logic ts_inc; // Internal counter steps this cycle.
  logic ts_wr; // Timestamp register written.
  logic ts_wrap; // Wrap event.
  logic [7:0] wd_count; // Live watchdog count.
  logic wd_timeout; // Watchdog expiry pulse.
  logic [1:0] rx_sync_reg; // Receive pin synchroniser.

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave. Zero wait states, always OKAY; reads are registered
  // from the address phase, so a read returns state as of that edge.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;

  // Capture write address; the data arrives one cycle later.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= wr_take;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    rdata_next = 32'h00000000;
    case (haddr[7:0])
      `CANRW_OFS_TEST: begin
        rdata_next[`CANRW_LOOP_BIT] = loopback_enable;
        rdata_next[`CANRW_TXCTL_LSB +: 2] = txctl_reg;
      end
      `CANRW_OFS_RWD: begin
        rdata_next[`CANRW_WD_START_LSB +: 8] = wd_start_reg;
        rdata_next[`CANRW_WD_COUNT_LSB +: 8] = wd_count;
      end
      `CANRW_OFS_CCCTL: begin
        rdata_next[`CANRW_INIT_BIT] = init_reg;
        rdata_next[`CANRW_CFG_CHG_BIT] = cfg_chg_reg;
        rdata_next[`CANRW_TEST_BIT] = test_reg;
      end
      `CANRW_OFS_TSCC: begin
        rdata_next[`CANRW_TS_SRC_LSB +: 2] = ts_src_reg;
        rdata_next[`CANRW_TS_PSC_LSB +: 4] = ts_psc_reg;
      end
      `CANRW_OFS_TSCV: begin
        rdata_next[15:0] = ts_now;
      end
      `CANRW_OFS_IRQ_STAT: begin
        rdata_next[1:0] = irq_stat_reg;
      end
      `CANRW_OFS_IRQ_EN: begin
        rdata_next[1:0] = irq_en_reg;
      end
      `CANRW_OFS_XIDAM: begin
        rdata_next[28:0] = mask_reg;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // Read data register; holds between reads.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      hrdata <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test and control registers.
  // loop back reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      loopback_enable <= 1'b0;
      txctl_reg <= canrw_pkg::canrw_tx_core;
    end else if (wr_pend_reg && wr_addr_reg == `CANRW_OFS_TEST) begin
      loopback_enable <= hwdata[`CANRW_LOOP_BIT];
      txctl_reg <= canrw_pkg::canrw_txctl_e'(hwdata[`CANRW_TXCTL_LSB +: 2]);
    end
  end

  // Initialisation, configuration change and test enables.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_reg <= `CANRW_INIT_RST;
      cfg_chg_reg <= 1'b0;
      test_reg <= 1'b0;
    end else if (wr_pend_reg && wr_addr_reg == `CANRW_OFS_CCCTL) begin
      init_reg <= hwdata[`CANRW_INIT_BIT];
      cfg_chg_reg <= hwdata[`CANRW_CFG_CHG_BIT];
      test_reg <= hwdata[`CANRW_TEST_BIT];
    end
  end

  // Watchdog start value; the count field is read-only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_start_reg <= 8'h00;
    end else if (wr_pend_reg && wr_addr_reg == `CANRW_OFS_RWD) begin
      wd_start_reg <= hwdata[`CANRW_WD_START_LSB +: 8];
    end
  end

  // Timestamp configuration.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts_src_reg <= canrw_pkg::canrw_ts_zero;
      ts_psc_reg <= 4'h0;
    end else if (wr_pend_reg && wr_addr_reg == `CANRW_OFS_TSCC) begin
      ts_src_reg <= canrw_pkg::canrw_ts_src_e'(hwdata[`CANRW_TS_SRC_LSB +: 2]);
      ts_psc_reg <= hwdata[`CANRW_TS_PSC_LSB +: 4];
    end
  end

  // Extended mask. Writes outside configuration are dropped silently,
  // which protects filters that are live on the bus.
  // reset all ones
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= `CANRW_XIDAM_RST;
    end else if (wr_pend_reg && wr_addr_reg == `CANRW_OFS_XIDAM && cfg_chg_reg && init_reg) begin
      mask_reg <= hwdata[28:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit pin and loop back. The pin is registered, one cycle behind.
  // forced pin levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      can_transmit_pin <= `CANRW_PIN_RST;
    end else if (test_reg && txctl_reg == canrw_pkg::canrw_tx_dominant) begin
      can_transmit_pin <= 1'b0;
    end else if (test_reg && txctl_reg == canrw_pkg::canrw_tx_recessive) begin
      can_transmit_pin <= 1'b1;
    end else begin
      can_transmit_pin <= core_tx;
    end
  end

  // Receive pin synchroniser, two flip-flops before any use.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sync_reg <= 2'b11;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], can_receive_pin};
    end
  end

  assign core_rx = loopback_enable ? core_tx : rx_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////////
  // RAM watchdog.
  // shared peripheral clock
  canrw_watchdog u_watchdog (
    .clk(clk),
    .rst_b(rst_b),
    .start_value(wd_start_reg),
    .access_start(ram_access_start),
    .ram_ready(ram_ready),
    .count_now(wd_count),
    .timeout(wd_timeout)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Timestamp.
  assign ts_wr = wr_pend_reg && wr_addr_reg == `CANRW_OFS_TSCV;
  assign ts_inc = ts_src_reg == canrw_pkg::canrw_ts_int && bit_time_tick && psc_reg == ts_psc_reg;

  always_comb begin
    case (ts_src_reg)
      canrw_pkg::canrw_ts_int: ts_now = ts_int_reg;
      canrw_pkg::canrw_ts_ext: ts_now = ext_timestamp;
      default: ts_now = 16'h0000;
    endcase
  end

  // Prescaler counts bit-time ticks, 1 to 16 per step.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psc_reg <= 4'h0;
    end else if (ts_wr || ts_src_reg != canrw_pkg::canrw_ts_int || ts_inc) begin
      psc_reg <= 4'h0;
    end else if (bit_time_tick) begin
      psc_reg <= psc_reg + 4'h1;
    end
  end

  // Internal counter. A write clears it, whatever the data, unless the
  // external source is selected, when the write has no effect.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts_int_reg <= 16'h0000;
    end else if (ts_wr && ts_src_reg != canrw_pkg::canrw_ts_ext) begin
      ts_int_reg <= 16'h0000;
    end else if (ts_inc) begin
      ts_int_reg <= ts_int_reg + 16'h0001;
    end
  end

  // External value history for wrap detection.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_prev_reg <= 16'h0000;
    end else begin
      ext_prev_reg <= ext_timestamp;
    end
  end

  assign ts_wrap = (ts_inc && ts_int_reg == 16'hFFFF && !ts_wr) ||
    (ts_src_reg == canrw_pkg::canrw_ts_ext && ext_prev_reg != 16'h0000 &&
    ext_timestamp == 16'h0000);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      captured_timestamp <= 16'h0000;
    end else if (frame_start) begin
      captured_timestamp <= ts_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Acceptance mask, one cycle of latency.
  // AND with identifier
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      masked_id_valid <= 1'b0;
      masked_ext_id <= 29'h0;
    end else begin
      masked_id_valid <= rx_id_valid;
      if (rx_id_valid) begin
        masked_ext_id <= rx_ext_id & mask_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts. A set in the same cycle as its clear wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_en_reg <= 2'b00;
    end else if (wr_pend_reg && wr_addr_reg == `CANRW_OFS_IRQ_EN) begin
      irq_en_reg <= hwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= 2'b00;
    end else begin
      irq_stat_reg[`CANRW_IRQ_WRAP_BIT] <= ts_wrap || (irq_stat_reg[`CANRW_IRQ_WRAP_BIT] &&
        !(wr_pend_reg && wr_addr_reg == `CANRW_OFS_IRQ_CLR && hwdata[`CANRW_IRQ_WRAP_BIT]));
      irq_stat_reg[`CANRW_IRQ_WDTO_BIT] <= wd_timeout || (irq_stat_reg[`CANRW_IRQ_WDTO_BIT] &&
        !(wr_pend_reg && wr_addr_reg == `CANRW_OFS_IRQ_CLR && hwdata[`CANRW_IRQ_WDTO_BIT]));
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_mask_locked_wr;
    wr_pend_reg && wr_addr_reg == `CANRW_OFS_XIDAM && !(cfg_chg_reg && init_reg);
  endsequence

  a_tx_dominant: assert property (@(posedge clk) disable iff (!rst_b)
    test_reg && txctl_reg == canrw_pkg::canrw_tx_dominant |=> !can_transmit_pin)
    else $error("pin not dominant in test mode");
  a_tx_recessive: assert property (@(posedge clk) disable iff (!rst_b)
    test_reg && txctl_reg == canrw_pkg::canrw_tx_recessive |=> can_transmit_pin)
    else $error("pin not recessive in test mode");
  a_loop_path: assert property (@(posedge clk) disable iff (!rst_b)
    loopback_enable |-> core_rx == core_tx)
    else $error("loop back path broken");
  a_ts_clear: assert property (@(posedge clk) disable iff (!rst_b)
    ts_wr && ts_src_reg != canrw_pkg::canrw_ts_ext |=> ts_int_reg == 16'h0000)
    else $error("timestamp write did not clear");
  a_ts_capture: assert property (@(posedge clk) disable iff (!rst_b)
    frame_start |=> captured_timestamp == $past(ts_now))
    else $error("timestamp not captured");
  a_ts_wrap_flag: assert property (@(posedge clk) disable iff (!rst_b)
    ts_src_reg == canrw_pkg::canrw_ts_int && ts_int_reg == 16'hFFFF && ts_inc && !ts_wr
      |=> ts_int_reg == 16'h0000 && irq_stat_reg[`CANRW_IRQ_WRAP_BIT])
    else $error("wrap not flagged");
  a_mask_apply: assert property (@(posedge clk) disable iff (!rst_b)
    rx_id_valid |=> masked_id_valid && masked_ext_id == ($past(rx_ext_id) & $past(mask_reg)))
    else $error("mask not applied");
  a_mask_locked: assert property (@(posedge clk) disable iff (!rst_b)
    s_mask_locked_wr |=> $stable(mask_reg))
    else $error("mask changed while locked");
  a_ts_external: assert property (@(posedge clk) disable iff (!rst_b)
    ts_src_reg == canrw_pkg::canrw_ts_ext |-> ts_now == ext_timestamp)
    else $error("external timestamp not shown");

endmodule : canrw_top

`default_nettype wire

// ===== verification/canrw_ram_model.sv
// Behavioural message RAM seen from the watchdog: issues accesses, answers late or never.
// Assumes the bench pulses go for one clk cycle; everything runs on clk.
`default_nettype none

module canrw_ram_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [7:0] delay,
  output logic ram_access_start,
  output logic ram_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] wait_reg; // Cycles left until the RAM answers.
  logic busy_reg; // An access is waiting for its answer.

  ////////////////////////////////////////////////////////////////////////
  // Delay 0 means the RAM never answers, which is how a timeout is provoked.
  // ready after delay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_access_start <= 1'b0;
      ram_ready <= 1'b0;
      busy_reg <= 1'b0;
      wait_reg <= 8'h00;
    end else begin
      ram_access_start <= go;
      ram_ready <= 1'b0;
      if (go) begin
        busy_reg <= (delay != 8'h00);
        wait_reg <= delay;
      end else if (busy_reg) begin
        // The ready pulse lasts one cycle and ends the access.
        if (wait_reg == 8'h01) begin
          ram_ready <= 1'b1;
          busy_reg <= 1'b0;
        end
        wait_reg <= wait_reg - 8'h01;
      end
    end
  end
endmodule : canrw_ram_model

`default_nettype wire

// ===== verification/tb_can_ram_watchdog_timestamp_mask.sv
// Self-checking bench: AHB-Lite register access, RAM watchdog, timestamp, mask, pin.
// Assumes canrw_top, its header and the RAM model are compiled before it.
`include "canrw_regs.svh"
`default_nettype none

module tb_can_ram_watchdog_timestamp_mask;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0; // Held low for two cycles at start.
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0; // Asks the RAM model for an access.
  logic [7:0] delay = 8'h00;
  logic bit_time_tick = 1'b0;
  logic frame_start = 1'b0;
  logic rx_id_valid = 1'b0;
  logic core_tx = 1'b0;
  logic can_receive_pin = 1'b1; // Recessive idle level.
  logic [15:0] ext_timestamp = 16'h0000;
  logic [28:0] rx_ext_id = 29'h0;
  logic hreadyout, hresp, irq, ram_access_start, ram_ready, masked_id_valid;
  logic core_rx, can_transmit_pin, loopback_enable;
  logic [31:0] hrdata;
  logic [31:0] rv;
  logic [31:0] rv2;
  logic [15:0] captured_timestamp;
  logic [28:0] masked_ext_id;
  int fail_count = 0;
  int checks_done = 0;

  always #2 clk = ~clk;

  // The single slave's hreadyout is the bus ready.
  canrw_top dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .irq, .ram_access_start, .ram_ready,
    .bit_time_tick, .frame_start, .ext_timestamp, .captured_timestamp, .rx_id_valid,
    .rx_ext_id, .masked_id_valid, .masked_ext_id, .core_tx, .core_rx, .can_transmit_pin,
    .can_receive_pin, .loopback_enable);

  canrw_ram_model ram (.clk, .rst_b, .go, .delay, .ram_access_start, .ram_ready);

  ////////////////////////////////////////////////////////////////////////
  // Compare, report and close.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////
  // Waits for one edge with hready high; a stuck bus ends the run.
  task automatic ready_edge();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      fail_count++;
      $display("unexpected at %0t ns: bus never ready", $time);
      conclude();
    end
  endtask : ready_edge

  // One single word transfer: address phase, then data phase, both held until ready.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ready_edge();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, exp);
  endtask : rd

  // Holds the bit tick high for exactly n sampling edges.
  task automatic ticks(input int n);
    @(posedge clk);
    bit_time_tick <= 1'b1;
    repeat (n) @(posedge clk);
    bit_time_tick <= 1'b0;
  endtask : ticks

  // Start of frame pulse, then the captured value is compared.
  task automatic frame(input logic [15:0] exp);
    @(posedge clk);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    #1;
    check({16'h0, captured_timestamp}, {16'h0, exp});
  endtask : frame

  // One received identifier, compared one edge later.
  task automatic id(input logic [28:0] i, input logic [28:0] e);
    @(posedge clk);
    rx_id_valid <= 1'b1;
    rx_ext_id <= i;
    @(posedge clk);
    rx_id_valid <= 1'b0;
    #1;
    check({3'h0, masked_ext_id}, {3'h0, e});
    check({31'h0, masked_id_valid}, 32'h1);
  endtask : id

  // Starts one RAM access through the model.
  task automatic access(input logic [7:0] d);
    @(posedge clk);
    go <= 1'b1;
    delay <= d;
    @(posedge clk);
    go <= 1'b0;
  endtask : access

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(`CANRW_OFS_XIDAM, 32'h1FFFFFFF);
    rd(`CANRW_OFS_RWD, 32'h0);
    rd(8'h40, 32'h0); // Unmapped place reads zero.
    check({31'h0, loopback_enable}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("reset test done");
    // Timeout first while masked, then seen on irq once enabled.
    wr(`CANRW_OFS_RWD, 32'h3);
    access(8'h00);
    repeat (10) @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h0);
    rd(`CANRW_OFS_IRQ_STAT, 32'h2);
    rd(`CANRW_OFS_RWD, 32'h3);
    wr(`CANRW_OFS_IRQ_EN, 32'h2);
    #1;
    check({31'h0, irq}, 32'h1);
    wr(`CANRW_OFS_IRQ_CLR, 32'h2);
    #1;
    check({31'h0, irq}, 32'h0);
    // Live count drops by the 3 cycles between address phases, then reloads.
    wr(`CANRW_OFS_RWD, 32'h30);
    access(8'd40);
    bus(1'b0, `CANRW_OFS_RWD, 32'h0, rv);
    bus(1'b0, `CANRW_OFS_RWD, 32'h0, rv2);
    check({24'h0, rv[15:8] - rv2[15:8]}, 32'h3);
    repeat (50) @(posedge clk);
    rd(`CANRW_OFS_RWD, 32'h3030);
    rd(`CANRW_OFS_IRQ_STAT, 32'h0);
    wr(`CANRW_OFS_RWD, 32'h0);
    access(8'h00);
    repeat (20) @(posedge clk);
    rd(`CANRW_OFS_IRQ_STAT, 32'h0);
    $display("watchdog test done");
    // Internal timestamp, prescale 1 and 4.
    wr(`CANRW_OFS_TSCC, 32'h1);
    wr(`CANRW_OFS_TSCV, 32'h0);
    ticks(5);
    rd(`CANRW_OFS_TSCV, 32'h5);
    wr(`CANRW_OFS_TSCC, 32'h00030001);
    wr(`CANRW_OFS_TSCV, 32'hFFFF);
    ticks(8);
    rd(`CANRW_OFS_TSCV, 32'h2);
    frame(16'h0002);
    wr(`CANRW_OFS_TSCV, 32'h1234);
    rd(`CANRW_OFS_TSCV, 32'h0);
    rd(`CANRW_OFS_IRQ_STAT, 32'h0);
    wr(`CANRW_OFS_TSCC, 32'h1);
    ticks(65536);
    rd(`CANRW_OFS_IRQ_STAT, 32'h1);
    wr(`CANRW_OFS_IRQ_CLR, 32'h1);
    // External source is shown as is and ignores writes.
    wr(`CANRW_OFS_TSCC, 32'h2);
    ext_timestamp <= 16'h1234;
    wr(`CANRW_OFS_TSCV, 32'h0);
    rd(`CANRW_OFS_TSCV, 32'h1234);
    frame(16'h1234);
    $display("timestamp test done");
    // Mask writes need both configuration change and init set.
    wr(`CANRW_OFS_XIDAM, 32'h0F0F0F0F);
    rd(`CANRW_OFS_XIDAM, 32'h1FFFFFFF);
    id(29'h1ABCDEF1, 29'h1ABCDEF1);
    wr(`CANRW_OFS_CCCTL, 32'h3);
    wr(`CANRW_OFS_XIDAM, 32'h0F0F0F0F);
    rd(`CANRW_OFS_XIDAM, 32'h0F0F0F0F);
    id(29'h1ABCDEF1, 29'h0A0C0E01);
    wr(`CANRW_OFS_CCCTL, 32'h0);
    wr(`CANRW_OFS_XIDAM, 32'hFFFFFFFF);
    rd(`CANRW_OFS_XIDAM, 32'h0F0F0F0F);
    $display("mask test done");
    // Every pin control code, core bit set against the forced level.
    wr(`CANRW_OFS_CCCTL, 32'h81);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      core_tx <= ~c[0];
      wr(`CANRW_OFS_TEST, 32'(c) << 5);
      @(posedge clk);
      #1;
      check({31'h0, can_transmit_pin}, {31'h0, c[1] ? c[0] : ~c[0]});
    end
    wr(`CANRW_OFS_TEST, 32'h10);
    rd(`CANRW_OFS_TEST, 32'h10);
    @(posedge clk);
    core_tx <= 1'b1;
    can_receive_pin <= 1'b0;
    // Three edges carry the low pin through both synchroniser stages, so only
    // the loop back path can still show a one here.
    repeat (3) @(posedge clk);
    #1;
    check({31'h0, core_rx}, 32'h1);
    check({31'h0, loopback_enable}, 32'h1);
    wr(`CANRW_OFS_TEST, 32'h0);
    #1;
    check({31'h0, core_rx}, 32'h0);
    $display("pin test done");
    conclude();
  end
endmodule : tb_can_ram_watchdog_timestamp_mask

`default_nettype wire
